// ==== design/wdg_pkg.sv ====
// Constants, register map and types of the watchdog block.
// Assumes a single 10 MHz APB clock and a separate power-on reset.
`default_nettype none
package wdg_pkg;
  localparam int unsigned PCLK_PERIOD_NS = 100;
  localparam int unsigned ACCESS_WINDOW_NS = 100000;
  // Longest allowed gap between the two writes, rounded down to whole cycles.
  localparam int unsigned ACCESS_WINDOW_CYC = ACCESS_WINDOW_NS / PCLK_PERIOD_NS;
  localparam int unsigned DIV_LOW = 256;
  localparam int unsigned DIV_HIGH = 16384;
  localparam int unsigned PRESC_W = 14;
  localparam int unsigned CNT_W = 16;

  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  localparam int unsigned C0_INIT_BIT = 0;
  localparam int unsigned C0_LOCK_BIT = 1;
  localparam int unsigned C0_PW_LO = 2;
  localparam int unsigned C0_PW_HI = 7;
  localparam int unsigned C0_UPW_LO = 8;
  localparam int unsigned C0_UPW_HI = 15;
  localparam int unsigned C0_REL_LO = 16;
  localparam int unsigned C0_REL_HI = 31;
  localparam int unsigned C1_DIS_BIT = 0;
  localparam int unsigned C1_FSEL_BIT = 1;
  localparam int unsigned ST_MODE_LO = 2;
  localparam int unsigned ST_UNLOCK_BIT = 4;
  localparam int unsigned ST_CNT_LO = 16;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_ACCERR = 0;
  localparam int unsigned IRQ_OVF = 1;
  localparam int unsigned IRQ_INITCHG = 2;

  localparam logic [5:0] FIXED_PW = 6'h31;
  localparam logic [7:0] USER_PW_RST = 8'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] TIMEOUT_RELOAD = 16'hfffc;
  localparam logic [15:0] PREWARN_RELOAD = 16'hff00;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  typedef enum logic [1:0] {
    WDG_NORMAL = 2'b00,
    WDG_TIMEOUT = 2'b01,
    WDG_PREWARN = 2'b11,
    WDG_RSTREQ = 2'b10
  } wdg_mode_t;
endpackage
`default_nettype wire

// ==== design/wdg_top.sv ====
// Watchdog with init-done protection line, prewarning and double reset detection.
// Assumes an APB3 master on pclk; presetn is the system reset, porst_n the power-on reset.
// Behaviour
// R1: The counter advances once per 256 or once per 16384 clocks, as software selects.
// R2: A proper modify access reloads the 16-bit counter from software's value, while time-out and prewarning use fixed values.
// R3: While enabled, an unserviced watchdog ends in a system reset request.
// R4: An error first raises the non-maskable interrupt and requests reset only after the prewarning period.
// R5: The unit holds the init-done bit, drives it onto the protection line and flags every change of it.
// R6: The control word changes only through two consecutive writes whose spacing the unit measures and bounds.
// R7: The first-write password combines a fixed field with a software-defined field.
// R8: A wrong password on the first write or wrong guard bits on the second start reset generation.
// R9: Counter overflow starts reset generation.
// R10: Software may disable the time-out function while password checking and init-done monitoring stay active; the code obeys disable in normal mode only.
// R11: Two watchdog resets with no proper access between them hold the chip in reset until power-on reset.
// R12: A second write arriving after the allowed window counts as an access error.
`timescale 1ns/1ps
`default_nettype none
module wdg_top #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DIV_LOW = wdg_pkg::DIV_LOW,
  parameter int unsigned DIV_HIGH = wdg_pkg::DIV_HIGH,
  parameter int unsigned WINDOW_CYC = wdg_pkg::ACCESS_WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic porst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic init_done_protect_bit,
  output logic nmi,
  output logic sys_reset_req,
  output logic reset_hold,
  output logic irq
);
  if (DIV_LOW < 2 || DIV_HIGH <= DIV_LOW || DIV_HIGH > (1 << wdg_pkg::PRESC_W)) begin : g_chk_div
    $error("wdg_top: divider values out of range");
  end
  if (WINDOW_CYC < 1 || WINDOW_CYC > 65535) begin : g_chk_win
    $error("wdg_top: access window out of range");
  end

  localparam logic [13:0] DIV_LOW_M1 = 14'(DIV_LOW - 1);
  localparam logic [13:0] DIV_HIGH_M1 = 14'(DIV_HIGH - 1);
  localparam logic [15:0] WIN_LOAD = 16'(WINDOW_CYC);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  wdg_pkg::wdg_mode_t mode_reg;
  logic [15:0] cnt_reg;
  logic [13:0] presc_reg;
  logic [15:0] reload_reg;
  logic [7:0] user_pw_reg;
  logic init_done_protect_bit_reg;
  logic unlocked_reg;
  logic [15:0] win_cnt_reg;
  logic disable_reg;
  logic fsel_reg;
  logic [wdg_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [wdg_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic nmi_reg;
  logic sys_reset_req_reg;
  logic wdt_rst_seen_reg;
  logic reset_hold_reg;
  logic irq_reg;

  logic acc;
  logic wr_c0;
  logic wr_c1;
  logic first_wr;
  logic second_wr;
  logic pw_ok;
  logic guard_ok;
  logic in_window;
  logic good_mod;
  logic acc_err;
  logic counting;
  logic tick;
  logic ovf;
  logic err_evt;
  logic rst_evt;
  logic mapped;
  logic [31:0] rd_next;

  assign acc = psel & penable & pready_reg;
  assign wr_c0 = acc & pwrite & hit(paddr, wdg_pkg::OFF_CTRL0);
  assign wr_c1 = acc & pwrite & hit(paddr, wdg_pkg::OFF_CTRL1);
  assign first_wr = wr_c0 & ~unlocked_reg;
  assign second_wr = wr_c0 & unlocked_reg;
  // Fixed field plus the software-chosen byte, lock bit clear.
  assign pw_ok = (pwdata[wdg_pkg::C0_PW_HI:wdg_pkg::C0_PW_LO] == wdg_pkg::FIXED_PW) // R7
    & ~pwdata[wdg_pkg::C0_LOCK_BIT]
    & (pwdata[wdg_pkg::C0_UPW_HI:wdg_pkg::C0_UPW_LO] == user_pw_reg);
  assign guard_ok = (pwdata[wdg_pkg::C0_PW_HI:wdg_pkg::C0_PW_LO] == wdg_pkg::FIXED_PW)
    & pwdata[wdg_pkg::C0_LOCK_BIT];
  assign in_window = (win_cnt_reg != 16'h0000); // R6
  assign good_mod = second_wr & guard_ok & in_window;
  assign acc_err = (first_wr & ~pw_ok) | (second_wr & ~(guard_ok & in_window)); // R8 R12
  // Disable only stops normal counting; the password path above stays live.
  assign counting = (mode_reg != wdg_pkg::WDG_RSTREQ) // R10
    & ~((mode_reg == wdg_pkg::WDG_NORMAL) & disable_reg);
  assign tick = fsel_reg ? (presc_reg >= DIV_HIGH_M1) : (presc_reg >= DIV_LOW_M1); // R1
  assign ovf = tick & counting & (cnt_reg == wdg_pkg::CNT_MAX); // R9
  assign err_evt = (acc_err | ovf) & ((mode_reg == wdg_pkg::WDG_NORMAL) // R3
    | (mode_reg == wdg_pkg::WDG_TIMEOUT));
  assign rst_evt = ovf & (mode_reg == wdg_pkg::WDG_PREWARN); // R4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 14'h0000;
    end else if (tick) begin
      presc_reg <= 14'h0000;
    end else begin
      presc_reg <= presc_reg + 14'h0001;
    end
  end

  // Reset starts in time-out mode with init-done clear, so boot code must close it in time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= wdg_pkg::WDG_TIMEOUT;
      cnt_reg <= wdg_pkg::TIMEOUT_RELOAD;
    end else if (rst_evt) begin
      mode_reg <= wdg_pkg::WDG_RSTREQ;
    end else if (err_evt) begin
      mode_reg <= wdg_pkg::WDG_PREWARN;
      cnt_reg <= wdg_pkg::PREWARN_RELOAD; // R4
    end else if (good_mod && mode_reg != wdg_pkg::WDG_PREWARN && mode_reg != wdg_pkg::WDG_RSTREQ) begin
      if (pwdata[wdg_pkg::C0_INIT_BIT]) begin
        mode_reg <= wdg_pkg::WDG_NORMAL;
        cnt_reg <= pwdata[wdg_pkg::C0_REL_HI:wdg_pkg::C0_REL_LO]; // R2
      end else begin
        mode_reg <= wdg_pkg::WDG_TIMEOUT;
        cnt_reg <= wdg_pkg::TIMEOUT_RELOAD; // R2
      end
    end else if (tick && counting) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked_reg <= 1'b0;
      win_cnt_reg <= 16'h0000;
    end else if (first_wr && pw_ok) begin
      unlocked_reg <= 1'b1;
      win_cnt_reg <= WIN_LOAD; // R6
    end else if (second_wr) begin
      unlocked_reg <= 1'b0;
      win_cnt_reg <= 16'h0000;
    end else if (in_window) begin
      win_cnt_reg <= win_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_protect_bit_reg <= 1'b0;
      reload_reg <= wdg_pkg::RELOAD_RST;
      user_pw_reg <= wdg_pkg::USER_PW_RST;
    end else if (good_mod) begin
      init_done_protect_bit_reg <= pwdata[wdg_pkg::C0_INIT_BIT]; // R5
      reload_reg <= pwdata[wdg_pkg::C0_REL_HI:wdg_pkg::C0_REL_LO];
      user_pw_reg <= pwdata[wdg_pkg::C0_UPW_HI:wdg_pkg::C0_UPW_LO];
    end
  end

  // The configuration word itself sits behind the init-done protection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disable_reg <= 1'b0;
      fsel_reg <= 1'b0;
    end else if (wr_c1 && !init_done_protect_bit_reg) begin
      disable_reg <= pwdata[wdg_pkg::C1_DIS_BIT];
      fsel_reg <= pwdata[wdg_pkg::C1_FSEL_BIT];
    end
  end

  // Only bits that were actually returned by the read are cleared, and new events win.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg
        & ~((acc && !pwrite && hit(paddr, wdg_pkg::OFF_IRQ_STAT)) ?
            prdata_reg[wdg_pkg::IRQ_W-1:0] : '0))
        | {(good_mod && (init_done_protect_bit_reg != pwdata[wdg_pkg::C0_INIT_BIT])), ovf, acc_err}; // R5
      if (acc && pwrite && hit(paddr, wdg_pkg::OFF_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[wdg_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_reg <= 1'b0;
      sys_reset_req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      nmi_reg <= (mode_reg == wdg_pkg::WDG_PREWARN) | (mode_reg == wdg_pkg::WDG_RSTREQ) | err_evt;
      sys_reset_req_reg <= sys_reset_req_reg | rst_evt | reset_hold_reg; // R3 R11
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Survives system reset; a proper modify access or power-on reset forgets an earlier watchdog reset, and only power-on reset clears the hold.
  always_ff @(posedge pclk or negedge porst_n) begin
    if (!porst_n) begin
      wdt_rst_seen_reg <= 1'b0;
      reset_hold_reg <= 1'b0;
    end else if (rst_evt) begin
      wdt_rst_seen_reg <= 1'b1;
      reset_hold_reg <= reset_hold_reg | wdt_rst_seen_reg; // R11
    end else if (good_mod) begin
      wdt_rst_seen_reg <= 1'b0;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_next = 32'h0000_0000;
    if (hit(paddr, wdg_pkg::OFF_CTRL0)) begin
      rd_next[wdg_pkg::C0_INIT_BIT] = init_done_protect_bit_reg;
      rd_next[wdg_pkg::C0_LOCK_BIT] = unlocked_reg;
      rd_next[wdg_pkg::C0_UPW_HI:wdg_pkg::C0_UPW_LO] = user_pw_reg;
      rd_next[wdg_pkg::C0_REL_HI:wdg_pkg::C0_REL_LO] = reload_reg;
    end else if (hit(paddr, wdg_pkg::OFF_CTRL1)) begin
      rd_next[wdg_pkg::C1_DIS_BIT] = disable_reg;
      rd_next[wdg_pkg::C1_FSEL_BIT] = fsel_reg;
    end else if (hit(paddr, wdg_pkg::OFF_STAT)) begin
      rd_next[wdg_pkg::C0_INIT_BIT] = init_done_protect_bit_reg;
      rd_next[wdg_pkg::ST_MODE_LO+1:wdg_pkg::ST_MODE_LO] = mode_reg;
      rd_next[wdg_pkg::ST_UNLOCK_BIT] = unlocked_reg;
      rd_next[wdg_pkg::ST_CNT_LO+15:wdg_pkg::ST_CNT_LO] = cnt_reg;
    end else if (hit(paddr, wdg_pkg::OFF_IRQ_STAT)) begin
      rd_next[wdg_pkg::IRQ_W-1:0] = irq_stat_reg;
    end else if (hit(paddr, wdg_pkg::OFF_IRQ_MASK)) begin
      rd_next[wdg_pkg::IRQ_W-1:0] = irq_mask_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data and error flags are registered in the setup phase, so the access phase completes without a wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & ~penable;
      if (psel && !penable) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr_reg <= ~mapped | (pwrite & (hit(paddr, wdg_pkg::OFF_STAT)
          | hit(paddr, wdg_pkg::OFF_IRQ_STAT)
          | (hit(paddr, wdg_pkg::OFF_CTRL1) & init_done_protect_bit_reg)));
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign init_done_protect_bit = init_done_protect_bit_reg; // R5
  assign nmi = nmi_reg;
  assign sys_reset_req = sys_reset_req_reg;
  assign reset_hold = reset_hold_reg;
  assign irq = irq_reg;

  sequence s_unlock;
    first_wr && pw_ok;
  endsequence
  sequence s_close;
    good_mod && pwdata[wdg_pkg::C0_INIT_BIT];
  endsequence
  property p_prescale;
    @(posedge pclk) disable iff (!presetn)
      tick && !fsel_reg && $stable(fsel_reg) |-> presc_reg == DIV_LOW_M1;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler tick at wrong count"); // R1
  // An overflow in the same cycle as a proper modify wins and starts prewarning instead.
  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      s_close and (!ovf && (mode_reg == wdg_pkg::WDG_NORMAL || mode_reg == wdg_pkg::WDG_TIMEOUT))
      |=> cnt_reg == reload_reg && mode_reg == wdg_pkg::WDG_NORMAL;
  endproperty
  a_reload: assert property (p_reload) else $error("normal reload value not used"); // R2
  property p_prewarn_first;
    @(posedge pclk) disable iff (!presetn)
      $rose(sys_reset_req_reg) && !reset_hold_reg |-> $past(nmi_reg, 2);
  endproperty
  a_prewarn_first: assert property (p_prewarn_first) else $error("reset without prewarning"); // R4
  property p_err_nmi;
    @(posedge pclk) disable iff (!presetn)
      acc_err && mode_reg != wdg_pkg::WDG_PREWARN && mode_reg != wdg_pkg::WDG_RSTREQ
      |=> mode_reg == wdg_pkg::WDG_PREWARN && cnt_reg == wdg_pkg::PREWARN_RELOAD ##1 nmi_reg;
  endproperty
  a_err_nmi: assert property (p_err_nmi) else $error("access error did not start prewarning"); // R8
  property p_init_flag;
    @(posedge pclk) disable iff (!presetn)
      $changed(init_done_protect_bit_reg) |-> irq_stat_reg[wdg_pkg::IRQ_INITCHG];
  endproperty
  a_init_flag: assert property (p_init_flag) else $error("init-done change not flagged"); // R5
  property p_window;
    @(posedge pclk) disable iff (!presetn)
      s_unlock |=> unlocked_reg && win_cnt_reg == WIN_LOAD;
  endproperty
  a_window: assert property (p_window) else $error("unlock window not opened"); // R6
  property p_late;
    @(posedge pclk) disable iff (!presetn)
      second_wr && !in_window
      && (mode_reg == wdg_pkg::WDG_NORMAL || mode_reg == wdg_pkg::WDG_TIMEOUT)
      |=> mode_reg == wdg_pkg::WDG_PREWARN && !unlocked_reg && irq_stat_reg[wdg_pkg::IRQ_ACCERR];
  endproperty
  a_late: assert property (p_late) else $error("late second write accepted"); // R12
  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
      ovf && (mode_reg == wdg_pkg::WDG_NORMAL || mode_reg == wdg_pkg::WDG_TIMEOUT)
      |=> mode_reg == wdg_pkg::WDG_PREWARN ##1 nmi_reg;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow did not start prewarning"); // R9
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == wdg_pkg::WDG_NORMAL && disable_reg && !acc_err && !good_mod |=> $stable(cnt_reg);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled counter moved"); // R10
  // Both flags are checked one edge later, before the system reset can clear the request.
  property p_double;
    @(posedge pclk) disable iff (!porst_n)
      rst_evt && wdt_rst_seen_reg |=> reset_hold_reg && sys_reset_req_reg;
  endproperty
  a_double: assert property (p_double) else $error("second watchdog reset not held"); // R11
endmodule
`default_nettype wire

// ==== tb/wdg_cpu_model.sv ====
// Bus master standing in for the software that services the watchdog.
// Assumes the watchdog answers on pclk with pready; the caller enters xfer just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module wdg_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; an idle edge follows so that back-to-back calls never drive twice in a step.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err, output bit ok);
    int n;
    ok = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok = 1'b1;
      end
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep showing the last word.
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/wdg_top_tb_top.sv ====
// Self-checking bench for the watchdog: service, errors, prewarning and double reset.
// Assumes shortened divider and window parameters; every figure below derives from them.
`timescale 1ns/1ps
`default_nettype none
module wdg_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic porst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, init_done_protect_bit, nmi;
  logic sys_reset_req, reset_hold, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v, w;
  int errors = 0;
  int check_count = 0;
  int n;

  always #50 pclk = ~pclk;

  wdg_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  wdg_top #(.ADDR_W(8), .DIV_LOW(16), .DIV_HIGH(64), .WINDOW_CYC(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .porst_n(porst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .init_done_protect_bit(init_done_protect_bit), .nmi(nmi),
    .sys_reset_req(sys_reset_req), .reset_hold(reset_hold), .irq(irq));

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rng(input string what, input int lo, input int hi, input logic [31:0] got);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic xf(input logic wr, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r, output logic e);
    bit ok;
    i_cpu.xfer(wr, a, d, r, e, ok);
    if (!ok) begin
      errors++;
      $display("ERROR pready expected 1 seen 0");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit ck, input logic ee);
    logic [31:0] r;
    logic e;
    xf(1'b1, a, d, r, e);
    if (ck) begin
      chk("pslverr", {31'h0, ee}, {31'h0, e});
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    xf(1'b0, a, 32'h00000000, r, e);
  endtask

  function automatic logic [31:0] cw(logic [15:0] rel, logic [7:0] pw, logic [1:0] lo);
    return {rel, pw, wdg_pkg::FIXED_PW, lo};
  endfunction

  task automatic wait_hi(input bit rst, input int lim, output int k);
    k = 0;
    while (((rst ? sys_reset_req : nmi) !== 1'b1) && k < lim) begin
      @(posedge pclk);
      k++;
    end
    if (k >= lim) begin
      errors++;
      $display("ERROR wait expected 1 seen 0");
      end_of_test();
    end
  endtask

  task automatic do_reset(input bit por);
    presetn <= 1'b0;
    if (por) begin
      porst_n <= 1'b0;
    end
    cyc(10);
    presetn <= 1'b1;
    porst_n <= 1'b1;
    @(posedge pclk);
  endtask

  // Three cycles of read overhead sit between the two counter samples.
  task automatic rate(input int k);
    logic [31:0] a;
    logic [31:0] b;
    rd(wdg_pkg::OFF_STAT, a);
    cyc(k);
    rd(wdg_pkg::OFF_STAT, b);
    rng("count rate", 9, 11, {16'h0000, b[31:16] - a[31:16]});
  endtask

  initial begin
    do_reset(1'b1);
    rd(wdg_pkg::OFF_STAT, v);
    chk("stat low", 32'h00000004, {16'h0000, v[15:0]});
    chk("protect line", 32'h0, {31'h0, init_done_protect_bit});
    wr(wdg_pkg::OFF_IRQ_MASK, 32'h00000007, 1'b1, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, cw(16'h0000, 8'h00, 2'b00), 1'b0, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, cw(16'h1000, 8'h5a, 2'b11), 1'b0, 1'b0);
    chk("protect line", 32'h1, {31'h0, init_done_protect_bit});
    // The interrupt line follows the status bit one edge later.
    cyc(1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(wdg_pkg::OFF_STAT, v);
    chk("mode", 32'h0, {30'h0, v[3:2]});
    rng("reload", 32'h1000, 32'h1002, {16'h0000, v[31:16]});
    rate(160);
    rd(wdg_pkg::OFF_IRQ_STAT, v);
    chk("irq stat", 32'h00000004, v);
    cyc(1);
    chk("irq", 32'h0, {31'h0, irq});
    rd(wdg_pkg::OFF_IRQ_STAT, v);
    chk("irq stat", 32'h0, v);
    wr(wdg_pkg::OFF_CTRL1, 32'h00000001, 1'b1, 1'b1);
    xf(1'b0, 8'h20, 32'h0, v, w[0]);
    chk("unmapped read", 32'h0, v);
    chk("unmapped err", 32'h1, {31'h0, w[0]});
    $display("Test service done");
    wr(wdg_pkg::OFF_CTRL0, cw(16'h0000, 8'h00, 2'b00), 1'b0, 1'b0);
    wait_hi(1'b0, 10, n);
    rng("nmi delay", 0, 3, n);
    rd(wdg_pkg::OFF_STAT, v);
    chk("mode", 32'h3, {30'h0, v[3:2]});
    rd(wdg_pkg::OFF_IRQ_STAT, v);
    chk("irq stat", 32'h00000001, v);
    wait_hi(1'b1, 5000, n);
    rng("prewarn length", 4050, 4110, n);
    chk("nmi", 32'h1, {31'h0, nmi});
    chk("hold", 32'h0, {31'h0, reset_hold});
    $display("Test access error done");
    do_reset(1'b0);
    wait_hi(1'b0, 200, n);
    rng("timeout length", 40, 70, n);
    wait_hi(1'b1, 5000, n);
    chk("hold", 32'h1, {31'h0, reset_hold});
    do_reset(1'b0);
    cyc(2);
    chk("held reset", 32'h1, {31'h0, sys_reset_req});
    $display("Test double reset done");
    do_reset(1'b1);
    chk("hold", 32'h0, {31'h0, reset_hold});
    wr(wdg_pkg::OFF_CTRL1, 32'h00000001, 1'b1, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, cw(16'h0000, 8'h00, 2'b00), 1'b0, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, cw(16'hfff0, 8'h00, 2'b11), 1'b0, 1'b0);
    cyc(600);
    chk("nmi", 32'h0, {31'h0, nmi});
    wr(wdg_pkg::OFF_CTRL0, cw(16'h0000, 8'h00, 2'b00), 1'b0, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, 32'h00000003, 1'b0, 1'b0);
    wait_hi(1'b0, 10, n);
    rng("nmi delay", 0, 3, n);
    $display("Test disable done");
    do_reset(1'b1);
    wr(wdg_pkg::OFF_CTRL1, 32'h00000002, 1'b1, 1'b0);
    wr(wdg_pkg::OFF_CTRL0, cw(16'h0000, 8'h00, 2'b00), 1'b0, 1'b0);
    cyc(25);
    wr(wdg_pkg::OFF_CTRL0, cw(16'h1000, 8'h00, 2'b11), 1'b0, 1'b0);
    wait_hi(1'b0, 10, n);
    rng("nmi delay", 0, 3, n);
    rate(640);
    $display("Test late access done");
    end_of_test();
  end
endmodule
`default_nettype wire
